// File: src/rtrf_filter.sv
/*
  Request filter and response framer for the contactless side of a tag
  memory, with the response payload FIFO.
  Assumes byte-level receive and transmit stages outside the block,
  a command executor on the user side, and power and field levels
  synchronous to clk.
*/
// Functional notes
// - Fixed 64-bit identifier, never changed by requests
// - Identifier: allocation byte, maker byte, 48-bit serial
// - Family identifier writable until locked, then refused
// - Family nibble and subfamily nibble, zero means all
// - Storage format identifier writable, then lockable
// - CRC-16 reflected, preset all ones
// - Two CRC bytes close every frame
// - Bad CRC drops the frame silently
// - Transmit only after an accepted request or a flag conflict error
// - Response: flags, parameters, data, CRC
// - Whole bytes, low byte first, LSB first
// - Optional field present only when flagged
// - Four states; field energy moves off to ready
// - Off only when unpowered and out of field
// - Ready answers unless select flag set
// - Quiet answers only addressed matching requests
// - Selected answers select, addressed, general requests
// - Addressed request needs identifier match
// - Non-addressed request carries no identifier
// - Select request answered only when selected
// - Select bit 5, address bit 6 when not inventory
// - Error flag bit 1 brings error code field
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Response payload FIFO
// ------------------------------------------------------------------
module rtrf_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic rdy;
  } rtrf_fifo_st_t;

  rtrf_fifo_st_t st_q;
  rtrf_fifo_st_t st_d;
  logic push;
  logic pop;

  assign in_ready = st_q.rdy;
  assign out_valid = (st_q.cnt != '0);
  assign out_data = st_q.mem[st_q.rp];

  always_comb begin
    st_d = st_q;
    push = in_valid && st_q.rdy;
    pop = out_ready && (st_q.cnt != '0);
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = st_q.wp + AW'(1);
    end
    if (pop) begin
      st_d.rp = st_q.rp + AW'(1);
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + CW'(1);
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - CW'(1);
    end
    // Registered ready so the source sees it straight from a flop
    st_d.rdy = (st_d.cnt != FULL_CNT);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.rdy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : rtrf_fifo

// ------------------------------------------------------------------
// Filter and framer top
// ------------------------------------------------------------------
module rtrf_filter
  import rtrf_pkg::*;
#(
  parameter logic [7:0] ALLOC_CODE = 8'hA5,   // Arbitrary value
  parameter logic [7:0] MAKER_CODE = 8'h5A,   // Arbitrary value
  parameter logic [47:0] SERIAL = 48'h0123_4567_89AB
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Power and field levels
  input wire logic field_on,
  input wire logic vcc_on,
  // State moves from the command executor
  input wire logic go_ready,
  input wire logic go_quiet,
  input wire logic go_select,
  // Received byte stream
  input wire rtrf_rx_t rx,
  // Accepted request and its byte buffer
  output rtrf_req_t req,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data,
  // Response command and payload
  input wire rtrf_rsp_t rsp,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  output logic rsp_ready,
  // Transmit byte stream
  output rtrf_txo_t tx,
  input wire logic tx_ready,
  // Identifier registers
  input wire rtrf_idwr_t id_wr,
  output logic [7:0] afi,
  output logic [7:0] dsfid,
  output logic afi_locked,
  output logic dsfid_locked,
  output logic wr_refused,
  output rtrf_tag_t tag_state
);
  // Read-only identifier, built from constants only
  localparam logic [63:0] UID = {ALLOC_CODE, MAKER_CODE, SERIAL};

  typedef struct packed {
    rtrf_tag_t tag;
    logic [7:0] afi;
    logic [7:0] dsfid;
    logic afi_lk;
    logic ds_lk;
    logic refused;
    logic [5:0] cnt;
    logic ovf;
    logic [15:0] rcrc;
    logic [7:0] rflags;
    logic [7:0] rcmd;
    logic [7:0] rafi;
    logic uid_mis;
    logic [BUF_DEPTH-1:0][7:0] rbuf;
    logic [7:0] rd;
    rtrf_req_t req;
    logic pend;
    rtrf_tx_t ts;
    logic [15:0] tcrc;
    logic terr;
    logic [7:0] tcode;
    logic thas;
    rtrf_txo_t tx;
  } rtrf_st_t;

  rtrf_st_t st_q;
  rtrf_st_t st_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic logic afi_match(input logic [7:0] want, input logic [7:0] own);
    logic fam;
    logic sub;
    fam = (want[7:4] == 4'h0) || (want[7:4] == own[7:4]);
    sub = (want[3:0] == 4'h0) || (want[3:0] == own[3:0]);
    return fam && sub;
  endfunction : afi_match

  // ----------------------------------------------------------------
  // FIFO in the response path
  // ----------------------------------------------------------------
  logic f_out_valid;
  logic [FIFO_W-1:0] f_out_data;
  logic f_pop;

  rtrf_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(rsp_valid),
    .in_data({rsp_last, rsp_data}),
    .in_ready(rsp_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_pop)
  );

  assign req = st_q.req;
  assign rd_data = st_q.rd;
  assign tx = st_q.tx;
  assign afi = st_q.afi;
  assign dsfid = st_q.dsfid;
  assign afi_locked = st_q.afi_lk;
  assign dsfid_locked = st_q.ds_lk;
  assign wr_refused = st_q.refused;
  assign tag_state = st_q.tag;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic inv;
  logic sel;
  logic adr;
  logic good;
  logic elig;
  logic load;
  logic [2:0] uidx;
  logic [7:0] ob;

  always_comb begin
    st_d = st_q;
    st_d.req.valid = 1'b0;
    st_d.refused = 1'b0;
    st_d.rd = st_q.rbuf[rd_addr];
    inv = 1'b0;
    sel = 1'b0;
    adr = 1'b0;
    good = 1'b0;
    elig = 1'b0;
    f_pop = 1'b0;
    ob = 8'h00;
    uidx = 3'(st_q.cnt - IDX_UID_FIRST);

    // Tag state
    if (!field_on && !vcc_on) begin
      st_d.tag = TAG_OFF;
    end else if (st_q.tag == TAG_OFF) begin
      if (field_on) begin
        st_d.tag = TAG_READY;
      end
    end else if (go_ready) begin
      st_d.tag = TAG_READY;
    end else if (go_select) begin
      st_d.tag = TAG_SEL;
    end else if (go_quiet) begin
      st_d.tag = TAG_QUIET;
    end

    // Identifier registers; lock survives only until reset here
    if (id_wr.afi_wr) begin
      if (st_q.afi_lk) begin
        st_d.refused = 1'b1;
      end else begin
        st_d.afi = id_wr.data;
      end
    end
    if (id_wr.afi_lock) begin
      st_d.afi_lk = 1'b1;
    end
    if (id_wr.dsfid_wr) begin
      if (st_q.ds_lk) begin
        st_d.refused = 1'b1;
      end else begin
        st_d.dsfid = id_wr.data;
      end
    end
    if (id_wr.dsfid_lock) begin
      st_d.ds_lk = 1'b1;
    end

    // Receive side: every byte after the start delimiter enters the CRC
    if (rx.sof) begin
      st_d.cnt = 6'h00;
      st_d.ovf = 1'b0;
      st_d.uid_mis = 1'b0;
      st_d.rcrc = CRC_PRESET;
    end
    if (rx.valid) begin
      st_d.rcrc = crc_byte(st_d.rcrc, rx.data);
      if (st_d.cnt < BUF_LIMIT) begin
        st_d.rbuf[st_d.cnt[4:0]] = rx.data;
      end
      if (st_d.cnt == IDX_FLAGS) begin
        st_d.rflags = rx.data;
      end
      if (st_d.cnt == IDX_CMD) begin
        st_d.rcmd = rx.data;
      end
      if (st_d.cnt == IDX_AFI) begin
        st_d.rafi = rx.data;
      end
      // Identifier arrives low byte first
      if (st_d.cnt >= IDX_UID_FIRST && st_d.cnt <= IDX_UID_LAST) begin
        uidx = 3'(st_d.cnt - IDX_UID_FIRST);
        if (rx.data != UID[{uidx, 3'b000} +: 8]) begin
          st_d.uid_mis = 1'b1;
        end
      end
      if (st_d.cnt == CNT_MAX) begin
        st_d.ovf = 1'b1;
      end else begin
        st_d.cnt = st_d.cnt + 6'h01;
      end
    end

    // End of frame: decide whether to answer
    if (rx.eof && st_q.ts == TX_IDLE) begin
      inv = st_d.rflags[RQ_INV_BIT];
      sel = !inv && st_d.rflags[RQ_SEL_BIT];
      adr = !inv && st_d.rflags[RQ_ADR_BIT];
      good = (st_d.rcrc == CRC_RESIDUE) && !st_d.ovf && (st_q.tag != TAG_OFF)
        && (st_d.cnt >= MIN_PLAIN_LEN);
      if (adr) begin
        // Identifier field only present with the address flag
        elig = (st_d.cnt >= MIN_ADDR_LEN) && !st_d.uid_mis;
      end else if (sel) begin
        elig = (st_q.tag == TAG_SEL);
      end else begin
        elig = (st_q.tag == TAG_READY) || (st_q.tag == TAG_SEL);
        if (inv && st_d.rflags[RQ_AFI_BIT]) begin
          elig = elig && (st_d.cnt >= MIN_AFI_LEN)
            && afi_match(st_d.rafi, st_q.afi);
        end
      end
      if (good && sel && adr) begin
        // Conflicting mode flags: answer with an error, never execute
        st_d.ts = TX_FLAGS;
        st_d.terr = 1'b1;
        st_d.tcode = ERR_FLAG_CONFLICT;
        st_d.thas = 1'b0;
        st_d.tcrc = CRC_PRESET;
        st_d.pend = 1'b0;
      end else if (good && elig) begin
        st_d.req.valid = 1'b1;
        st_d.req.flags = st_d.rflags;
        st_d.req.cmd = st_d.rcmd;
        st_d.req.len = st_d.cnt;
        st_d.pend = 1'b1;
      end
    end

    // Transmit side: an executor response only follows an accepted request
    if (st_q.ts == TX_IDLE && rsp.start && st_q.pend) begin
      st_d.ts = TX_FLAGS;
      st_d.terr = rsp.err;
      st_d.tcode = rsp.code;
      st_d.thas = rsp.has_data;
      st_d.tcrc = CRC_PRESET;
      st_d.pend = 1'b0;
    end

    if (st_q.tx.valid && tx_ready) begin
      st_d.tx.valid = 1'b0;
      st_d.tx.last = 1'b0;
    end
    load = !st_q.tx.valid || tx_ready;

    if (load) begin
      unique case (st_q.ts)
        TX_IDLE: begin
        end
        TX_FLAGS: begin
          ob = 8'h00;
          ob[RS_ERR_BIT] = st_q.terr;
          st_d.tx.valid = 1'b1;
          st_d.tx.data = ob;
          st_d.tcrc = crc_byte(st_q.tcrc, ob);
          st_d.ts = st_q.terr ? TX_CODE : (st_q.thas ? TX_DATA : TX_CRCL);
        end
        TX_CODE: begin
          st_d.tx.valid = 1'b1;
          st_d.tx.data = st_q.tcode;
          st_d.tcrc = crc_byte(st_q.tcrc, st_q.tcode);
          st_d.ts = st_q.thas ? TX_DATA : TX_CRCL;
        end
        TX_DATA: begin
          // Waits on the FIFO; a slow source just stretches the frame
          if (f_out_valid) begin
            f_pop = 1'b1;
            st_d.tx.valid = 1'b1;
            st_d.tx.data = f_out_data[7:0];
            st_d.tcrc = crc_byte(st_q.tcrc, f_out_data[7:0]);
            if (f_out_data[8]) begin
              st_d.ts = TX_CRCL;
            end
          end
        end
        TX_CRCL: begin
          st_d.tx.valid = 1'b1;
          st_d.tx.data = ~st_q.tcrc[7:0];
          st_d.ts = TX_CRCH;
        end
        TX_CRCH: begin
          st_d.tx.valid = 1'b1;
          st_d.tx.data = ~st_q.tcrc[15:8];
          st_d.tx.last = 1'b1;
          st_d.ts = TX_IDLE;
        end
        default: begin
          st_d.ts = TX_IDLE;
        end
      endcase
    end

    // Losing power and field abandons any pending answer
    if (st_d.tag == TAG_OFF) begin
      st_d.pend = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.tag <= TAG_OFF;
      st_q.ts <= TX_IDLE;
      st_q.rcrc <= CRC_PRESET;
      st_q.tcrc <= CRC_PRESET;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : rtrf_filter

`default_nettype wire

// File: src/rtrf_pkg.sv
/*
  Package for the contactless request filter: frame layout constants,
  CRC constants, tag states, transmit states and the packed carriers.
  Assumes a byte-level receiver and transmitter sit outside the block.
*/
package rtrf_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int BUF_DEPTH = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 9;
  localparam logic [5:0] IDX_FLAGS = 6'h00;
  localparam logic [5:0] IDX_CMD = 6'h01;
  localparam logic [5:0] IDX_UID_FIRST = 6'h02;
  localparam logic [5:0] IDX_UID_LAST = 6'h09;
  localparam logic [5:0] IDX_AFI = 6'h02;
  localparam logic [5:0] MIN_PLAIN_LEN = 6'h04;
  localparam logic [5:0] MIN_ADDR_LEN = 6'h0C;
  localparam logic [5:0] MIN_AFI_LEN = 6'h05;
  localparam logic [5:0] BUF_LIMIT = 6'h20;
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // Request flag positions (bit 1 of the byte is index 0)
  localparam int RQ_INV_BIT = 2;
  localparam int RQ_SEL_BIT = 4;
  localparam int RQ_ADR_BIT = 5;
  localparam int RQ_AFI_BIT = 4;
  localparam int RS_ERR_BIT = 0;
  localparam logic [7:0] ERR_FLAG_CONFLICT = 8'h03;

  // ----------------------------------------------------------------
  // CRC
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TAG_OFF = 2'b00,
    TAG_READY = 2'b01,
    TAG_QUIET = 2'b10,
    TAG_SEL = 2'b11
  } rtrf_tag_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_FLAGS = 3'b001,
    TX_CODE = 3'b010,
    TX_DATA = 3'b011,
    TX_CRCL = 3'b100,
    TX_CRCH = 3'b101
  } rtrf_tx_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sof;
    logic valid;
    logic [7:0] data;
    logic eof;
  } rtrf_rx_t;

  typedef struct packed {
    logic valid;
    logic [7:0] flags;
    logic [7:0] cmd;
    logic [5:0] len;
  } rtrf_req_t;

  typedef struct packed {
    logic start;
    logic err;
    logic [7:0] code;
    logic has_data;
  } rtrf_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } rtrf_txo_t;

  typedef struct packed {
    logic afi_wr;
    logic afi_lock;
    logic dsfid_wr;
    logic dsfid_lock;
    logic [7:0] data;
  } rtrf_idwr_t;

endpackage : rtrf_pkg

// File: sim/rtrf_filter_asserts.sv
/*
  Port checker for the request filter.
  Assumes one clock domain; bound by the line at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module rtrf_filter_asserts
  import rtrf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Levels
  input wire logic field_on,
  input wire logic vcc_on,
  // Streams
  input wire rtrf_rx_t rx,
  input wire rtrf_req_t req,
  input wire rtrf_rsp_t rsp,
  input wire rtrf_txo_t tx,
  input wire logic tx_ready,
  // Identifiers and state
  input wire rtrf_idwr_t id_wr,
  input wire logic [7:0] afi,
  input wire logic [7:0] dsfid,
  input wire logic afi_locked,
  input wire logic dsfid_locked,
  input wire logic wr_refused,
  input wire rtrf_tag_t tag_state
);
  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_stall;
    tx.valid && !tx_ready;
  endsequence
  sequence s_locked_wr;
    (afi_locked && id_wr.afi_wr) || (dsfid_locked && id_wr.dsfid_wr);
  endsequence

  chk_tx_hold: assert property (s_stall |=> tx.valid && $stable(tx.data))
    else $error("tx byte moved while stalled");
  chk_last_end: assert property (tx.valid && tx_ready && tx.last |=> !tx.valid)
    else $error("frame ran on after crc");
  chk_talk_first: assert property ($rose(tx.valid) |->
    $past(rsp.start, 2) || $past(rx.eof, 2))
    else $error("tx without a request");
  // A frame not started by the executor can only be the flag conflict error
  chk_err_frame: assert property ($rose(tx.valid) && !$past(rsp.start, 2) |->
    tx.data == 8'h01)
    else $error("error frame flags wrong");
  chk_off_exit: assert property (tag_state == TAG_OFF && field_on |=>
    tag_state == TAG_READY)
    else $error("field did not wake tag");
  chk_off_entry: assert property (tag_state != TAG_OFF |=>
    (tag_state == TAG_OFF) == (!$past(field_on) && !$past(vcc_on)))
    else $error("power off entry wrong");
  chk_sel_only: assert property (req.valid && req.flags[RQ_SEL_BIT] &&
    !req.flags[RQ_INV_BIT] |-> $past(tag_state) == TAG_SEL && !req.flags[RQ_ADR_BIT])
    else $error("select request outside selected");
  chk_quiet_addr: assert property (req.valid && $past(tag_state) == TAG_QUIET |->
    req.flags[RQ_ADR_BIT] && !req.flags[RQ_INV_BIT])
    else $error("quiet tag took general request");
  chk_addr_len: assert property (req.valid && req.flags[RQ_ADR_BIT] &&
    !req.flags[RQ_INV_BIT] |-> req.len >= MIN_ADDR_LEN)
    else $error("addressed request too short");
  chk_lock_refuse: assert property (s_locked_wr |=>
    wr_refused && $stable(afi) && $stable(dsfid))
    else $error("locked identifier changed");
endmodule : rtrf_filter_asserts

bind rtrf_filter rtrf_filter_asserts chk_u (
  .clk(clk), .srst(srst), .field_on(field_on), .vcc_on(vcc_on), .rx(rx), .req(req),
  .rsp(rsp), .tx(tx), .tx_ready(tx_ready), .id_wr(id_wr), .afi(afi), .dsfid(dsfid),
  .afi_locked(afi_locked), .dsfid_locked(dsfid_locked), .wr_refused(wr_refused),
  .tag_state(tag_state)
);
`default_nettype wire

// File: sim/rtrf_reader.sv
/*
  Reader model: frames requests with CRC and collects response bytes.
  Assumes the bench calls send and reads got between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module rtrf_reader
  import rtrf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request stream
  output rtrf_rx_t rx,
  // Response stream
  input wire rtrf_txo_t tx,
  output logic tx_ready,
  // Stall every other cycle when high
  input wire logic slow
);
  logic [7:0] got[$];

  // ------------------
  // CRC and framing
  // ------------------
  function automatic logic [15:0] crc_add(logic [15:0] c, logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_add

  function automatic logic [15:0] crc_of(logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_PRESET;
    foreach (q[i]) c = crc_add(c, q[i]);
    return c;
  endfunction : crc_of

  // Bad flips one CRC bit so the frame must be dropped
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = ~crc_of(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8] ^ {7'h00, bad});
    foreach (q[i]) begin
      @(negedge clk);
      rx <= '{sof: (i == 0), valid: 1'h1, data: q[i], eof: 1'h0};
    end
    @(negedge clk);
    // Idle data line never repeats the last byte
    rx <= '{sof: 1'h0, valid: 1'h0, data: ~rx.data, eof: 1'h1};
    @(negedge clk);
    rx.eof <= 1'h0;
  endtask : send

  initial begin
    rx = '0;
    tx_ready = 1'h1;
  end
  always @(negedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'h1;
  end
  always @(posedge clk) begin
    if (tx.valid && tx_ready) begin
      got.push_back(tx.data);
    end
  end
endmodule : rtrf_reader
`default_nettype wire

// File: sim/rtrf_filter_tb.sv
/*
  Bench for the request filter with the reader model on the far side.
  Assumes the package, the design and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module rtrf_filter_tb
  import rtrf_pkg::*;
;
  localparam logic [63:0] UID = 64'h3C96_0102_0304_0506; // Arbitrary value
  logic clk, srst, field_on, vcc_on, go_ready, go_quiet, go_select, slow, seen;
  logic rsp_valid, rsp_last, rsp_ready, tx_ready, afi_locked, dsfid_locked, wr_refused;
  logic [7:0] rd_data, rsp_data, afi, dsfid;
  logic [4:0] rd_addr;
  rtrf_rx_t rx;
  rtrf_req_t req;
  rtrf_rsp_t rsp;
  rtrf_txo_t tx;
  rtrf_idwr_t id_wr;
  rtrf_tag_t tag_state;
  int fails, checks, cyc;

  rtrf_filter #(.ALLOC_CODE(UID[63:56]), .MAKER_CODE(UID[55:48]), .SERIAL(UID[47:0])) dut_u (
    .clk(clk), .srst(srst), .field_on(field_on), .vcc_on(vcc_on), .go_ready(go_ready),
    .go_quiet(go_quiet), .go_select(go_select), .rx(rx), .req(req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rsp(rsp), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready), .tx(tx), .tx_ready(tx_ready),
    .id_wr(id_wr), .afi(afi), .dsfid(dsfid), .afi_locked(afi_locked),
    .dsfid_locked(dsfid_locked), .wr_refused(wr_refused), .tag_state(tag_state));
  rtrf_reader rd_u (.clk(clk), .rx(rx), .tx(tx), .tx_ready(tx_ready), .slow(slow));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    seen <= seen | req.valid;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic test_done();
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic ask(input logic [7:0] fl, input logic [7:0] b2, input logic [63:0] u,
                     input logic bad, input logic exp);
    logic [7:0] q[$];
    q = '{fl, 8'h20};
    if (fl[RQ_ADR_BIT] && !fl[RQ_INV_BIT]) begin
      for (int i = 0; i < 8; i++) begin
        q.push_back(u[8*i +: 8]);
      end
    end
    if (fl[RQ_INV_BIT] && fl[RQ_AFI_BIT]) begin
      q.push_back(b2);
    end
    seen = 1'h0;
    rd_u.got.delete();
    rd_u.send(q, bad);
    repeat (3) @(negedge clk);
    cmp("accept", exp, seen);
    if (exp) begin
      cmp("req flags", fl, req.flags);
      cmp("req len", q.size() + 2, req.len);
    end
  endtask : ask

  task automatic collect(input logic [7:0] head[$]);
    int k;
    k = 0;
    // Sampled on falling edges, where the design's outputs have settled
    while (!tx.last && k < 400) begin
      @(negedge clk);
      k++;
    end
    while (tx.valid && k < 400) begin
      @(negedge clk);
      k++;
    end
    cmp("rsp size", head.size() + 2, rd_u.got.size());
    foreach (head[i]) cmp("rsp byte", head[i], rd_u.got[i]);
    cmp("rsp crc", CRC_RESIDUE, rd_u.crc_of(rd_u.got));
  endtask : collect

  task automatic answer(input int n);
    logic [7:0] h[$];
    h = '{8'h00};
    for (int i = 0; i < n; i++) begin
      rsp_valid = 1'h1;
      rsp_data = 8'hC0 + i[7:0];
      rsp_last = (i == n - 1);
      h.push_back(rsp_data);
      @(negedge clk);
      cmp("fifo ready", (i < FIFO_DEPTH - 1), rsp_ready);
    end
    rsp_valid = 1'h0;
    rsp = '{start: 1'h1, err: 1'h0, code: 8'h00, has_data: (n > 0)};
    @(negedge clk);
    rsp.start = 1'h0;
    collect(h);
    cmp("fifo drained", 1'h1, rsp_ready);
  endtask : answer

  task automatic move(input logic [2:0] g, input rtrf_tag_t st);
    {go_ready, go_select, go_quiet} = g;
    @(negedge clk);
    {go_ready, go_select, go_quiet} = 3'h0;
    @(negedge clk);
    cmp("state", st, tag_state);
  endtask : move

  task automatic idw(input logic [3:0] k, input logic [7:0] d, input logic r);
    id_wr = '{afi_wr: k[3], afi_lock: k[2], dsfid_wr: k[1], dsfid_lock: k[0], data: d};
    @(negedge clk);
    id_wr = '0;
    cmp("refused", r, wr_refused);
  endtask : idw

  task automatic t_power();
    cmp("reset state", TAG_OFF, tag_state);
    cmp("reset ids", 16'h0, {afi, dsfid});
    ask(8'h02, 8'h00, UID, 1'h0, 1'h0);
    vcc_on = 1'h1;
    @(negedge clk);
    cmp("vcc only", TAG_OFF, tag_state);
    field_on = 1'h1;
    @(negedge clk);
    cmp("field on", TAG_READY, tag_state);
    field_on = 1'h0;
    repeat (2) @(negedge clk);
    cmp("field lost", TAG_READY, tag_state);
    field_on = 1'h1;
    ask(8'h02, 8'h00, UID, 1'h1, 1'h0);
    rsp = '{start: 1'h1, err: 1'h0, code: 8'h00, has_data: 1'h0};
    @(negedge clk);
    rsp.start = 1'h0;
    repeat (4) @(negedge clk);
    cmp("silent", 16'h0, rd_u.got.size());
  endtask : t_power

  task automatic t_ident();
    idw(4'h8, 8'h35, 1'h0);
    idw(4'h2, 8'h9C, 1'h0);
    idw(4'h5, 8'h00, 1'h0);
    idw(4'h8, 8'h77, 1'h1);
    idw(4'h2, 8'h11, 1'h1);
    cmp("ids", 16'h359C, {afi, dsfid});
    cmp("locks", 16'h3, {afi_locked, dsfid_locked});
  endtask : t_ident

  // Acceptance per state (ready, quiet, selected) and request kind
  task automatic t_modes();
    logic [11:0] want;
    logic [7:0] af[5] = '{8'h00, 8'h30, 8'h05, 8'h36, 8'h45};
    want = 12'h745;
    for (int s = 0; s < 3; s++) begin
      if (s == 1) begin
        move(3'h1, TAG_QUIET);
      end
      if (s == 2) begin
        move(3'h2, TAG_SEL);
      end
      for (int c = 0; c < 4; c++) begin
        ask((c == 0) ? 8'h02 : (c == 1) ? 8'h12 : 8'h22, 8'h00,
            (c == 3) ? ~UID : UID, 1'h0, want[4*s+c]);
      end
    end
    cmp("buffered cmd", 8'h20, rd_data);
    for (int i = 0; i < 5; i++) begin
      ask(8'h16, af[i], UID, 1'h0, (i < 3));
    end
    ask(8'h32, 8'h00, UID, 1'h0, 1'h0);
    collect('{8'h01, 8'h03});
  endtask : t_modes

  task automatic t_resp();
    ask(8'h02, 8'h00, UID, 1'h0, 1'h1);
    answer(0);
    slow = 1'h1;
    ask(8'h02, 8'h00, UID, 1'h0, 1'h1);
    answer(FIFO_DEPTH);
    slow = 1'h0;
    {field_on, vcc_on} = 2'h0;
    repeat (2) @(negedge clk);
    cmp("power off", TAG_OFF, tag_state);
  endtask : t_resp

  initial begin
    {clk, srst, field_on, vcc_on, slow, seen} = 6'h10;
    {go_ready, go_quiet, go_select, rsp_valid, rsp_last} = 5'h0;
    rsp_data = 8'h00;
    rd_addr = 5'h01;
    rsp = '0;
    id_wr = '0;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    t_power();
    t_ident();
    t_modes();
    t_resp();
    test_done();
  end
endmodule : rtrf_filter_tb
`default_nettype wire
